//--- logic/cpc_map.vh
// Purpose: Address map, field layout and codes of the core power controller
// Assumes: Included by every design file of the block
// Notes:   Definitions only
`ifndef CPC_MAP_VH
`define CPC_MAP_VH

// Register byte addresses
`define CPC_ADDR_W        12
`define CPC_OFF_ADDR      12'h000
`define CPC_ON_ADDR       12'h004
`define CPC_CLOFF_ADDR    12'h008
`define CPC_WAKE_ADDR     12'h00c
`define CPC_STAT_ADDR     12'h010

// Affinity layout
`define CPC_AFF_W         24
`define CPC_AFF_MSB       23
`define CPC_L2_MSB        23
`define CPC_L2_LSB        16
`define CPC_L1_MSB        15
`define CPC_L1_LSB        8
`define CPC_L0_MSB        7
`define CPC_L0_LSB        0
`define CPC_CPU_IDX_MSB   1
`define CPC_AFF_RESET     24'h00_0000
`define CPC_LVL_ZERO      8'h00
`define CPC_RSVD_BYTE     8'h00
`define CPC_RSVD_WAKE     7'h00
`define CPC_WORD_ZERO     32'h0000_0000

// Wakeup register
`define CPC_WEN_BIT       31

// Status register
`define CPC_ST_L2         31
`define CPC_ST_L1         30
`define CPC_ST_L0         29
`define CPC_ST_WEN        28
`define CPC_ST_CPEND      27
`define CPC_ST_PP         26
`define CPC_ST_WHY_MSB    25
`define CPC_ST_WHY_LSB    24

// Power-on reason codes
`define CPC_WHY_COLD      2'h0
`define CPC_WHY_RESET     2'h1
`define CPC_WHY_PON       2'h2
`define CPC_WHY_IRQ       2'h3

// Topology: two clusters of four cores
`define CPC_NCORE         8
`define CPC_NCLUS         2
`define CPC_IDX_W         3
`define CPC_NCLUS_B       8'h02
`define CPC_CPC_B         8'h04
`define CPC_CPC_LOG       2

// Default startup list: every core of cluster 0
`define CPC_STARTUP       8'h0f

`endif

//--- logic/cpc_sync.v
// Purpose: Three-stage input synchroniser with agreement filter
// Assumes: Input comes from outside the pclk domain
// Notes:   Output follows only once stages two and three agree
`include "cpc_map.vh"

module cpc_sync #(
    parameter W = 1
) (
    input  wire         pclk,
    input  wire         presetn,
    input  wire         pce,
    input  wire [W-1:0] d,
    output reg  [W-1:0] q
);

reg [W-1:0] s1;
reg [W-1:0] s2;
reg [W-1:0] s3;

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        s1 <= {W{1'b0}};
        s2 <= {W{1'b0}};
        s3 <= {W{1'b0}};
        q  <= {W{1'b0}};
    end
    else if (pce)
    begin
        // First stage feeds only the second
        s1 <= d;
        s2 <= s1;
        s3 <= s2;
        if (s2 == s3)
        begin
            q <= s3;
        end
    end
end

endmodule // cpc_sync

//--- logic/cpc_core_slot.v
// Purpose: Power state of one core
// Assumes: Request pulses are one pclk cycle wide and already checked
// Notes:   Startup bit is a constant, so reset loads no port value
`include "cpc_map.vh"

module cpc_core_slot #(
    parameter STARTUP = 1'b0
) (
    input  wire       pclk,
    input  wire       presetn,
    input  wire       pce,
    input  wire       sys_reset,
    input  wire       off_req,
    input  wire       on_req,
    input  wire       wen_wr,
    input  wire       wen_val,
    input  wire       cluster_down,
    input  wire       wake_irq,
    input  wire       standby,
    output reg        powered,
    output reg        pending_off,
    output reg        wake_en,
    output reg  [1:0] reason
);

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        powered     <= STARTUP;
        pending_off <= 1'b0;
        wake_en     <= 1'b0;
        reason      <= `CPC_WHY_COLD;
    end
    else if (pce)
    begin
        if (sys_reset)
        begin
            powered     <= STARTUP;
            pending_off <= 1'b0;
            wake_en     <= 1'b0;
            reason      <= `CPC_WHY_RESET;
        end
        else
        begin
            if (wen_wr)
            begin
                wake_en <= wen_val;
            end
            if (cluster_down)
            begin
                powered     <= 1'b0;
                pending_off <= 1'b0;
            end
            else if (powered)
            begin
                if (pending_off && standby)
                begin
                    powered     <= 1'b0;
                    pending_off <= 1'b0;
                end
                else if (off_req)
                begin
                    pending_off <= 1'b1;
                end
            end
            else if (on_req)
            begin
                powered <= 1'b1;
                reason  <= `CPC_WHY_PON;
            end
            else if (wake_irq && wake_en)
            begin
                powered <= 1'b1;
                reason  <= `CPC_WHY_IRQ;
            end
        end
    end
end

endmodule // cpc_core_slot

//--- logic/cpc_top.v
// Purpose: Core power controller, APB register slave
// Assumes: req_affinity names the core issuing the current APB transfer
// Notes:   Every transfer takes two access cycles; errors answer with pslverr
//
// Summary of operation
// - Affinity is 24 bits, three byte levels
// - Startup list powers cores at reset
// - Startup list selects cores, one mask bit per core
// - Five registers at consecutive word offsets
// - Processor-off write suspends the core
// - Off target differing from requester errors
// - Processor-on write powers up named core
// - On target equal to requester errors
// - Cluster-off write turns whole cluster off
// - Wakeup bit plus affinity enables wake
// - Status reports 2-bit power-on reason
// - Status flags pending cluster-off
`include "cpc_map.vh"

module cpc_top #(
    parameter [`CPC_NCORE-1:0] STARTUP_MASK = `CPC_STARTUP
) (
    input  wire                   pclk,
    input  wire                   presetn,
    input  wire                   pce,
    input  wire                   psel,
    input  wire                   penable,
    input  wire                   pwrite,
    input  wire [`CPC_ADDR_W-1:0] paddr,
    input  wire [31:0]            pwdata,
    input  wire [`CPC_AFF_W-1:0]  req_affinity,
    input  wire                   sys_reset_n,
    input  wire [`CPC_NCORE-1:0]  wake_request,
    input  wire [`CPC_NCORE-1:0]  core_standby,
    input  wire [`CPC_NCLUS-1:0]  level2_standby_signal,
    output reg  [31:0]            prdata,
    output reg                    pready,
    output reg                    pslverr,
    output reg  [`CPC_NCORE-1:0]  core_power_on,
    output reg  [`CPC_NCLUS-1:0]  cluster_power_on
);

localparam ST_IDLE = 2'b01;
localparam ST_DONE = 2'b10;

reg  [1:0]             state;
reg  [1:0]             next_state;
reg  [`CPC_AFF_W-1:0]  off_reg;
reg  [`CPC_AFF_W-1:0]  on_reg;
reg  [`CPC_AFF_W-1:0]  cloff_reg;
reg  [`CPC_AFF_W-1:0]  wake_reg;
reg                    wake_bit;
reg  [`CPC_AFF_W-1:0]  stat_reg;
reg  [`CPC_NCLUS-1:0]  cl_pending;
reg  [31:0]            rd_word;
reg                    acc_err;
reg                    aff_ok;
reg                    stat_ok;
reg  [`CPC_IDX_W-1:0]  idx;
reg  [`CPC_IDX_W-1:0]  stat_idx;
reg                    is_off;
reg                    is_on;
reg                    is_cloff;
reg                    is_wake;

wire [`CPC_AFF_W-1:0]  wr_aff;
wire                   commit;
wire                   sys_reset_q;
wire [`CPC_NCORE-1:0]  wake_q;
wire [`CPC_NCORE-1:0]  standby_q;
wire [`CPC_NCLUS-1:0]  l2_standby_q;
wire [`CPC_NCORE-1:0]  powered;
wire [`CPC_NCORE-1:0]  pend_off;
wire [`CPC_NCORE-1:0]  wake_en;
wire [2*`CPC_NCORE-1:0] reason;
wire [`CPC_NCLUS-1:0]  cluster_down;
wire [`CPC_NCLUS-1:0]  cluster_any;

assign wr_aff = pwdata[`CPC_AFF_MSB:0];

// Writes act only at the edge that completes the transfer
assign commit = psel && penable && pwrite && pready && !pslverr
                && (state == ST_DONE);

// affinity decode, level 2 must be zero
function aff_valid;
    input [`CPC_AFF_W-1:0] a;
    begin
        aff_valid = (a[`CPC_L2_MSB:`CPC_L2_LSB] == `CPC_LVL_ZERO)
                    && (a[`CPC_L1_MSB:`CPC_L1_LSB] < `CPC_NCLUS_B)
                    && (a[`CPC_L0_MSB:`CPC_L0_LSB] < `CPC_CPC_B);
    end
endfunction

function [`CPC_IDX_W-1:0] aff_index;
    input [`CPC_AFF_W-1:0] a;
    begin
        aff_index = {a[`CPC_L1_LSB], a[`CPC_CPU_IDX_MSB:`CPC_L0_LSB]};
    end
endfunction

// Pins from outside the clock domain
cpc_sync #(.W(1)) u_sync_rst (
    .pclk    (pclk),
    .presetn (presetn),
    .pce     (pce),
    .d       (~sys_reset_n),
    .q       (sys_reset_q)
);

cpc_sync #(.W(`CPC_NCORE)) u_sync_wake (
    .pclk    (pclk),
    .presetn (presetn),
    .pce     (pce),
    .d       (wake_request),
    .q       (wake_q)
);

cpc_sync #(.W(`CPC_NCORE)) u_sync_stby (
    .pclk    (pclk),
    .presetn (presetn),
    .pce     (pce),
    .d       (core_standby),
    .q       (standby_q)
);

cpc_sync #(.W(`CPC_NCLUS)) u_sync_l2 (
    .pclk    (pclk),
    .presetn (presetn),
    .pce     (pce),
    .d       (level2_standby_signal),
    .q       (l2_standby_q)
);

// Decode and access check
always @*
begin
    aff_ok   = aff_valid(wr_aff);
    idx      = aff_index(wr_aff);
    stat_ok  = aff_valid(stat_reg);
    stat_idx = aff_index(stat_reg);
    is_off   = 1'b0;
    is_on    = 1'b0;
    is_cloff = 1'b0;
    is_wake  = 1'b0;
    rd_word  = `CPC_WORD_ZERO;
    acc_err  = 1'b0;
    case (paddr)
        `CPC_OFF_ADDR:
        begin
            is_off  = 1'b1;
            rd_word = {`CPC_RSVD_BYTE, off_reg};
            acc_err = pwrite && (!aff_ok || (wr_aff != req_affinity));
        end
        `CPC_ON_ADDR:
        begin
            is_on   = 1'b1;
            rd_word = {`CPC_RSVD_BYTE, on_reg};
            // on must not name the requester
            acc_err = pwrite && (!aff_ok || (wr_aff == req_affinity));
        end
        `CPC_CLOFF_ADDR:
        begin
            is_cloff = 1'b1;
            rd_word  = {`CPC_RSVD_BYTE, cloff_reg};
            acc_err  = pwrite && (!aff_ok || (wr_aff != req_affinity));
        end
        `CPC_WAKE_ADDR:
        begin
            is_wake = 1'b1;
            rd_word = {wake_bit, `CPC_RSVD_WAKE, wake_reg};
            acc_err = pwrite && !aff_ok;
        end
        `CPC_STAT_ADDR:
        begin
            acc_err = pwrite && !aff_ok;
            rd_word[`CPC_AFF_MSB:0] = stat_reg;
            if (stat_ok)
            begin
                // Level 2 is not implemented and reads as zero
                rd_word[`CPC_ST_L1] = cluster_any[stat_idx[`CPC_IDX_W-1]];
                rd_word[`CPC_ST_L0] = powered[stat_idx];
                rd_word[`CPC_ST_WEN] = wake_en[stat_idx];
                rd_word[`CPC_ST_CPEND] = cl_pending[stat_idx[`CPC_IDX_W-1]];
                rd_word[`CPC_ST_PP] = pend_off[stat_idx];
                rd_word[`CPC_ST_WHY_MSB:`CPC_ST_WHY_LSB] =
                    reason[2*stat_idx +: 2];
            end
        end
        default:
        begin
            acc_err = 1'b1;
        end
    endcase
end

// APB handshake: one wait cycle, then pready for one cycle
always @*
begin
    next_state = state;
    case (state)
        ST_IDLE:
        begin
            if (psel && penable)
            begin
                next_state = ST_DONE;
            end
        end
        ST_DONE:
        begin
            next_state = ST_IDLE;
        end
        default:
        begin
            next_state = ST_IDLE;
        end
    endcase
end

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        state   <= ST_IDLE;
        pready  <= 1'b0;
        pslverr <= 1'b0;
        prdata  <= `CPC_WORD_ZERO;
    end
    else if (pce)
    begin
        state <= next_state;
        if ((state == ST_IDLE) && psel && penable)
        begin
            pready  <= 1'b1;
            pslverr <= acc_err;
            prdata  <= pwrite ? `CPC_WORD_ZERO : rd_word;
        end
        else
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= `CPC_WORD_ZERO;
        end
    end
end

// Register storage
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        off_reg   <= `CPC_AFF_RESET;
        on_reg    <= `CPC_AFF_RESET;
        cloff_reg <= `CPC_AFF_RESET;
        wake_reg  <= `CPC_AFF_RESET;
        wake_bit  <= 1'b0;
        stat_reg  <= `CPC_AFF_RESET;
    end
    else if (pce && commit)
    begin
        case (paddr)
            `CPC_OFF_ADDR:   off_reg   <= wr_aff;
            `CPC_ON_ADDR:    on_reg    <= wr_aff;
            `CPC_CLOFF_ADDR: cloff_reg <= wr_aff;
            `CPC_WAKE_ADDR:
            begin
                wake_reg <= wr_aff;
                wake_bit <= pwdata[`CPC_WEN_BIT];
            end
            `CPC_STAT_ADDR:  stat_reg  <= wr_aff;
            default:         stat_reg  <= stat_reg;
        endcase
    end
end

// cluster waits for its level-2 standby
assign cluster_down = cl_pending & l2_standby_q;

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        cl_pending <= {`CPC_NCLUS{1'b0}};
    end
    else if (pce)
    begin
        if (sys_reset_q)
        begin
            cl_pending <= {`CPC_NCLUS{1'b0}};
        end
        else
        begin
            // A new request in the same cycle as completion wins
            cl_pending <= (cl_pending & ~cluster_down)
                          | ((commit && is_cloff) ?
                             ({{(`CPC_NCLUS-1){1'b0}}, 1'b1} << idx[`CPC_IDX_W-1])
                             : {`CPC_NCLUS{1'b0}});
        end
    end
end

genvar gi;
generate
    for (gi = 0; gi < `CPC_NCORE; gi = gi + 1)
    begin : g_core
        cpc_core_slot #(
            .STARTUP (STARTUP_MASK[gi])
        ) u_slot (
            .pclk         (pclk),
            .presetn      (presetn),
            .pce          (pce),
            .sys_reset    (sys_reset_q),
            // suspend request to the named core
            .off_req      (commit && is_off && (idx == gi)),
            // power-on request to the named core
            .on_req       (commit && is_on && (idx == gi)),
            .wen_wr       (commit && is_wake && (idx == gi)),
            .wen_val      (pwdata[`CPC_WEN_BIT]),
            .cluster_down (cluster_down[gi >> `CPC_CPC_LOG]),
            .wake_irq     (wake_q[gi]),
            .standby      (standby_q[gi]),
            .powered      (powered[gi]),
            .pending_off  (pend_off[gi]),
            .wake_en      (wake_en[gi]),
            .reason       (reason[2*gi +: 2])
        );
    end
    for (gi = 0; gi < `CPC_NCLUS; gi = gi + 1)
    begin : g_clus
        assign cluster_any[gi] = |powered[gi*4 +: 4];
    end
endgenerate

// Registered copies so outputs come from flops in this module
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        core_power_on    <= {`CPC_NCORE{1'b0}};
        cluster_power_on <= {`CPC_NCLUS{1'b0}};
    end
    else if (pce)
    begin
        core_power_on    <= powered;
        cluster_power_on <= cluster_any;
    end
end

endmodule // cpc_top

//--- test/cpc_top_sva.sv
// Purpose: Port-level checks of the core power controller
// Assumes: pce held high; bench keeps APB requests steady until pready
// Notes:   Bound to every cpc_top instance
`include "cpc_map.vh"

module cpc_chk #(
    parameter [`CPC_NCORE-1:0] STARTUP_MASK = `CPC_STARTUP
) (
    input wire logic                   pclk,
    input wire logic                   presetn,
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [`CPC_ADDR_W-1:0] paddr,
    input wire logic [31:0]            pwdata,
    input wire logic [`CPC_AFF_W-1:0]  req_affinity,
    input wire logic                   sys_reset_n,
    input wire logic [31:0]            prdata,
    input wire logic                   pready,
    input wire logic                   pslverr,
    input wire logic [`CPC_NCORE-1:0]  core_power_on
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Captured because pwdata is released before the core comes up
    logic [2:0] on_idx;
    always @(posedge pclk or negedge presetn)
        if (!presetn)
            on_idx <= 3'h0;
        else if (pready && pwrite && paddr == 12'h004)
            on_idx <= {pwdata[8], pwdata[1:0]};

    sequence s_access;
        psel && penable && !pready ##1 pready;
    endsequence
    sequence s_on_done;
        pready && pwrite && paddr == 12'h004 && !pslverr;
    endsequence
    sequence s_sys_low;
        $fell(sys_reset_n) ##1 !sys_reset_n [*7];
    endsequence

    property p_answer;
        $rose(penable) && psel |-> s_access;
    endproperty
    property p_pulse;
        pready |=> !pready;
    endproperty
    property p_unmapped;
        pready && (paddr > 12'h010 || paddr[1:0] != 2'b00) |-> pslverr && prdata == 32'h0000_0000;
    endproperty
    property p_rsvd;
        pready && !pwrite && paddr < 12'h00c |-> prdata[31:24] == 8'h00;
    endproperty
    property p_off_other;
        pready && pwrite && paddr == 12'h000 && pwdata[23:0] != req_affinity |-> pslverr;
    endproperty
    property p_on_self;
        pready && pwrite && paddr == 12'h004 && pwdata[23:0] == req_affinity |-> pslverr;
    endproperty
    property p_bad_aff;
        pready && pwrite && paddr <= 12'h008 && pwdata[23:16] != 8'h00 |-> pslverr;
    endproperty
    property p_on;
        s_on_done |-> ##[1:3] core_power_on[on_idx];
    endproperty
    property p_startup;
        $rose(presetn) |=> core_power_on == STARTUP_MASK;
    endproperty
    property p_sysrst;
        s_sys_low |-> core_power_on == STARTUP_MASK;
    endproperty

    a_answer: assert property (p_answer)
        else $error("access not answered in its second cycle");
    a_pulse: assert property (p_pulse)
        else $error("pready longer than one cycle");
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped address accepted");
    a_rsvd: assert property (p_rsvd)
        else $error("reserved byte not zero");
    a_off_other: assert property (p_off_other)
        else $error("off request for another core accepted");
    a_on_self: assert property (p_on_self)
        else $error("on request for own core accepted");
    a_bad_aff: assert property (p_bad_aff)
        else $error("affinity with level 2 set accepted");
    a_on: assert property (p_on)
        else $error("named core not powered after on request");
    a_startup: assert property (p_startup)
        else $error("startup cores wrong after reset");
    a_sysrst: assert property (p_sysrst)
        else $error("startup cores wrong during system reset");
endmodule // cpc_chk

bind cpc_top cpc_chk #(.STARTUP_MASK(STARTUP_MASK)) chk (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .req_affinity,
    .sys_reset_n, .prdata, .pready, .pslverr, .core_power_on
);

//--- test/cpc_far_model.sv
// Purpose: Cores and interrupt distributor beside the controller
// Assumes: Bench asks for standby and wake per core
// Notes:   Standby lags the request by a chosen number of cycles
module cpc_far_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [7:0] sleep_req,
    input  wire logic [7:0] wake_req,
    input  wire logic [3:0] lag,
    output logic [7:0]      core_standby,
    output logic [1:0]      level2_standby_signal,
    output logic [7:0]      wake_request
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [127:0] pipe;

    always @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            pipe <= '0;
            wake_request <= 8'h00;
        end
        else
        begin
            pipe <= {pipe[119:0], sleep_req};
            wake_request <= wake_req;
        end

    assign core_standby = pipe[lag*8 +: 8];
    assign level2_standby_signal = {&core_standby[7:4], &core_standby[3:0]};
endmodule // cpc_far_model

//--- test/testbench.sv
// Purpose: Self-checking bench of the core power controller
// Assumes: Cores 0.0.0.x start powered
// Notes:   Requesting core given on req_affinity with every transfer
`include "cpc_map.vh"

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic        sys_reset_n = 1, pready, pslverr, err;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [23:0] req_affinity = '0;
    logic [7:0]  sleep_req = '0, wake_req = '0, core_standby, wake_request, core_power_on;
    logic [1:0]  level2_standby_signal, cluster_power_on;
    logic [3:0]  lag = '0;
    int          mismatches = 0, comparisons = 0, cycles = 0;

    cpc_top DUT (.pclk, .presetn, .pce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
        .req_affinity, .sys_reset_n, .wake_request, .core_standby, .level2_standby_signal,
        .prdata, .pready, .pslverr, .core_power_on, .cluster_power_on);
    cpc_far_model far (.pclk, .presetn, .sleep_req, .wake_req, .lag, .core_standby,
        .level2_standby_signal, .wake_request);

    always #20 pclk = ~pclk;

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            mismatches++;
            give_verdict();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [23:0] who);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        req_affinity <= who;
        @(posedge pclk);
        penable <= 1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
            mismatches++;
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    task automatic stat(input logic [23:0] aff);
        apb(1, 12'h010, {8'h00, aff}, 24'h00_0000);
        apb(0, 12'h010, 32'h0000_0000, 24'h00_0000);
    endtask

    // Waits on {cluster, core} power levels, bounded
    task automatic wait_pwr(input logic [9:0] m, input logic [9:0] v);
        int n;
        n = 0;
        while (({cluster_power_on, core_power_on} & m) !== v && n < 40)
        begin
            @(posedge pclk);
            n++;
        end
        chk({cluster_power_on, core_power_on} & m, v);
    endtask

    task automatic t_reset;
        chk(core_power_on, 8'h0f);
        chk(cluster_power_on, 2'b01);
        stat(24'h00_0000);
        chk(rd, 32'h6000_0000);
        for (int a = 0; a <= 16; a += 4)
        begin
            apb(0, a[11:0], 32'h0000_0000, 24'h00_0000);
            chk(err, 1'b0);
        end
        apb(0, 12'h014, 32'h0000_0000, 24'h00_0000);
        chk({rd[31:1], err}, 32'h0000_0001);
    endtask

    task automatic t_on;
        // Core 0 wakes the off core 0.0.1.0 only
        // on targets off core
        apb(1, 12'h004, 32'hff00_0100, 24'h00_0000);
        chk(err, 1'b0);
        wait_pwr(10'h3f0, 10'h310);
        apb(0, 12'h004, 32'h0000_0000, 24'h00_0000);
        chk(rd, 32'h0000_0100);
        stat(24'h00_0100);
        chk(rd, 32'h6200_0100);
        apb(1, 12'h004, 32'h0000_0100, 24'h00_0100);
        chk(err, 1'b1);
        apb(1, 12'h004, 32'h0001_0000, 24'h00_0000);
        chk(err, 1'b1);
        apb(1, 12'h004, 32'h0000_0004, 24'h00_0000);
        chk(err, 1'b1);
    endtask

    task automatic t_off;
        apb(1, 12'h000, 32'h0000_0001, 24'h00_0000);
        chk(err, 1'b1);
        apb(1, 12'h000, 32'h0000_0100, 24'h00_0100);
        chk(err, 1'b0);
        stat(24'h00_0100);
        chk(rd, 32'h6600_0100);
        lag <= 4'h9;
        sleep_req <= 8'h10;
        wait_pwr(10'h3f0, 10'h100);
        sleep_req <= 8'h00;
        chk(core_power_on, 8'h0f);
    endtask

    task automatic t_wake;
        apb(1, 12'h00c, 32'h8000_0100, 24'h00_0000);
        chk(err, 1'b0);
        stat(24'h00_0100);
        chk(rd[28], 1'b1);
        wake_req <= 8'h30;
        wait_pwr(10'h3f0, 10'h310);
        wake_req <= 8'h00;
        stat(24'h00_0100);
        chk(rd[25:24], 2'b11);
        chk(core_power_on[5], 1'b0);
    endtask

    task automatic t_cluster;
        apb(1, 12'h008, 32'h0000_0100, 24'h00_0100);
        chk(err, 1'b0);
        stat(24'h00_0100);
        chk(rd[27], 1'b1);
        lag <= 4'h0;
        sleep_req <= 8'hf0;
        wait_pwr(10'h3ff, 10'h10f);
        sleep_req <= 8'h00;
    endtask

    task automatic t_sysrst;
        apb(1, 12'h004, 32'h0000_0101, 24'h00_0000);
        wait_pwr(10'h3f0, 10'h320);
        sys_reset_n <= 0;
        repeat (10) @(posedge pclk);
        sys_reset_n <= 1;
        wait_pwr(10'h3ff, 10'h10f);
        stat(24'h00_0000);
        chk(rd[25:24], 2'b01);
    endtask

    initial
    begin
        repeat (16) @(posedge pclk);
        chk(core_power_on, 8'h00);
        presetn <= 1;
        repeat (2) @(posedge pclk);
        t_reset();
        t_on();
        t_off();
        t_wake();
        t_cluster();
        t_sysrst();
        give_verdict();
    end
endmodule // testbench
